// ### src/apmx_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * link power-state exit forwarding block.
 * Assumes a 250 MHz core clock and a 32-bit Avalon-MM slave with byte offsets.
 */
`ifndef APMX_REGS_VH
`define APMX_REGS_VH

// =============================================================
// Register byte offsets
`define APMX_OFF_LINK_CAP      4'h0
`define APMX_OFF_LINK_CTRL     4'h4
`define APMX_OFF_LINK_STAT     4'h8
`define APMX_OFF_EXIT_STAT     4'hC

// =============================================================
// Field positions
`define APMX_CAP_SUPPORT_LSB   0
`define APMX_CAP_L0S_LAT_LSB   2
`define APMX_CAP_L1_LAT_LSB    5
`define APMX_CTRL_ENTRY_LSB    0
`define APMX_CTRL_CCLK_BIT     2
`define APMX_CTRL_RETRAIN_BIT  3
`define APMX_STAT_SCLK_BIT     0
`define APMX_EXIT_UP_BIT       0
`define APMX_EXIT_DN_LSB       1
`define APMX_EXIT_UP_L1_BIT    5
`define APMX_EXIT_DN_L1_LSB    6
`define APMX_EXIT_UP_LATE_BIT  10
`define APMX_EXIT_DN_LATE_BIT  11

// =============================================================
// Reset values
`define APMX_RST_ENTRY         2'h0
`define APMX_RST_CCLK          1'h0

// =============================================================
// Timing: forwarding deadline and the margin kept inside it
`define APMX_FWD_LIMIT_NS      1000
`define APMX_CLK_PERIOD_NS     4
`define APMX_FWD_LIMIT_CYC     (`APMX_FWD_LIMIT_NS / `APMX_CLK_PERIOD_NS)
`define APMX_FWD_DELAY_CYC     8'h04
// Forwarding limit in cycles, sized for the 8-bit supervision counters
`define APMX_FWD_LIMIT_CNT     8'hFA

`endif

// ### src/apmx_fwd_lane.v
/*
 * One exit-forwarding lane: sees an exit start request and raises the exit
 * command for its link after a short fixed delay, well inside the deadline.
 * Assumes link state inputs synchronous to clk_i.
 */
`timescale 1ns/10ps
`include "apmx_regs.vh"

module apmx_fwd_lane (
  input  wire clk_i,
  input  wire arst_n_i,
  input  wire trig_i,
  input  wire link_l1_i,
  input  wire block_i,
  output reg  exit_o
);

  reg [7:0] cnt_reg;
  reg       pend_reg;

  // =============================================================
  // Pending exit and delay counter
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_reg <= 1'b0;
      cnt_reg  <= 8'h00;
      exit_o   <= 1'b0;
    end else begin
      if (!link_l1_i || block_i) begin
        // Link left L1 or is held in low power: nothing to do
        pend_reg <= 1'b0;
        cnt_reg  <= 8'h00;
        exit_o   <= 1'b0;
      end else if (trig_i && !pend_reg) begin
        pend_reg <= 1'b1;
        cnt_reg  <= 8'h00;
      end else if (pend_reg && !exit_o) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg >= `APMX_FWD_DELAY_CYC - 8'h01) begin
          exit_o <= 1'b1;
        end
      end
    end
  end

endmodule // apmx_fwd_lane

// ### src/apmx_top.v
/*
 * Link power-state exit control for a switch: starts L1 exit on own traffic,
 * forwards exit across the switch, holds the power configuration bits.
 * Assumes link state, traffic and exit-detect inputs synchronous to clk_i;
 * the physical layer performs the actual exit once exit command is raised.
 */
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "apmx_regs.vh"

module apmx_top #(
  parameter [1:0] SUPPORT_VAL   = 2'h3,
  parameter [2:0] L0S_LAT_SEP   = 3'h5,
  parameter [2:0] L0S_LAT_COM   = 3'h3,
  parameter [2:0] L1_LAT_SEP    = 3'h4,
  parameter [2:0] L1_LAT_COM    = 3'h2
) (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        slot_clock_i,
  input  wire        up_link_l1_i,
  input  wire        up_exit_seen_i,
  input  wire        up_tx_pending_i,
  input  wire        retrain_done_i,
  input  wire [3:0]  dn_link_l1_i,
  input  wire [3:0]  dn_exit_seen_i,
  input  wire [3:0]  dn_tx_pending_i,
  input  wire [3:0]  dn_dstate_low_i,
  output reg         up_exit_o,
  output reg  [3:0]  dn_exit_o,
  output reg  [1:0]  lowpower_entry_enable_o,
  output reg         retrain_req_o
);

  reg  [1:0] lowpower_entry_enable_field_reg;
  reg        cclk_reg;
  reg        slot_clock_reg;
  reg        cclk_applied_reg;
  reg        ack_reg;
  reg [31:0] rdata_next;
  reg        up_fwd_seen_reg;
  reg  [3:0] dn_fwd_seen_reg;
  reg        up_dl_run_reg;
  reg        up_dl_run_next;
  reg  [7:0] up_dl_cnt_reg;
  reg  [7:0] up_dl_cnt_next;
  reg        up_late_reg;
  reg        up_late_next;
  reg        dn_dl_run_reg;
  reg        dn_dl_run_next;
  reg  [7:0] dn_dl_cnt_reg;
  reg  [7:0] dn_dl_cnt_next;
  reg  [3:0] dn_target_reg;
  reg  [3:0] dn_target_next;
  reg        dn_late_reg;
  reg        dn_late_next;

  wire       up_lane_exit;
  wire [3:0] dn_lane_exit;
  wire       any_dn_exit;
  wire [1:0] lowpower_support_field;
  wire [2:0] l0s_lat;
  wire [2:0] l1_lat;
  wire       acc;
  wire       wr;
  wire [3:0] dn_trig;
  wire       up_exit_begin;
  wire [3:0] dn_exit_begin;
  wire [3:0] dn_eligible;
  wire       dn_waiting;

  // =============================================================
  // Avalon slave: one wait state, answer on second edge
  assign acc = (avs_read_i || avs_write_i) && !ack_reg;
  assign wr  = avs_write_i && acc;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_reg           <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_reg           <= acc;
      avs_waitrequest_o <= !acc;
    end
  end

  // Support field is read-only; latency follows the applied clock mode
  assign lowpower_support_field = SUPPORT_VAL;
  assign l0s_lat = cclk_applied_reg ? L0S_LAT_COM : L0S_LAT_SEP;
  assign l1_lat  = cclk_applied_reg ? L1_LAT_COM  : L1_LAT_SEP;

  always @* begin
    rdata_next = 32'h00000000;
    case (avs_address_i)
      `APMX_OFF_LINK_CAP: begin
        rdata_next[`APMX_CAP_SUPPORT_LSB +: 2] = lowpower_support_field;
        rdata_next[`APMX_CAP_L0S_LAT_LSB +: 3] = l0s_lat;
        rdata_next[`APMX_CAP_L1_LAT_LSB +: 3]  = l1_lat;
      end
      `APMX_OFF_LINK_CTRL: begin
        rdata_next[`APMX_CTRL_ENTRY_LSB +: 2] = lowpower_entry_enable_field_reg;
        rdata_next[`APMX_CTRL_CCLK_BIT]       = cclk_reg;
      end
      `APMX_OFF_LINK_STAT: begin
        rdata_next[`APMX_STAT_SCLK_BIT] = slot_clock_reg;
      end
      `APMX_OFF_EXIT_STAT: begin
        rdata_next[`APMX_EXIT_UP_BIT]         = up_exit_o;
        rdata_next[`APMX_EXIT_DN_LSB +: 4]    = dn_exit_o;
        rdata_next[`APMX_EXIT_UP_L1_BIT]      = up_link_l1_i;
        rdata_next[`APMX_EXIT_DN_L1_LSB +: 4] = dn_link_l1_i;
        rdata_next[`APMX_EXIT_UP_LATE_BIT]    = up_late_reg;
        rdata_next[`APMX_EXIT_DN_LATE_BIT]    = dn_late_reg;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // =============================================================
  // Configuration registers
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lowpower_entry_enable_field_reg <= `APMX_RST_ENTRY;
      cclk_reg                        <= `APMX_RST_CCLK;
      cclk_applied_reg                <= `APMX_RST_CCLK;
      slot_clock_reg                  <= 1'b0;
      retrain_req_o                   <= 1'b0;
      avs_readdata_o                  <= 32'h00000000;
      lowpower_entry_enable_o         <= `APMX_RST_ENTRY;
    end else begin
      slot_clock_reg <= slot_clock_i;
      retrain_req_o  <= 1'b0;
      if (avs_read_i && acc) begin
        avs_readdata_o <= rdata_next;
      end
      if (wr && avs_address_i == `APMX_OFF_LINK_CTRL && avs_byteenable_i[0]) begin
        lowpower_entry_enable_field_reg <= avs_writedata_i[`APMX_CTRL_ENTRY_LSB +: 2];
        cclk_reg                        <= avs_writedata_i[`APMX_CTRL_CCLK_BIT];
        retrain_req_o                   <= avs_writedata_i[`APMX_CTRL_RETRAIN_BIT];
      end
      // Reported latency switches only once the link has retrained
      if (retrain_done_i) begin
        cclk_applied_reg <= cclk_reg;
      end
      lowpower_entry_enable_o <= lowpower_entry_enable_field_reg;
    end
  end

  // =============================================================
  // Exit forwarding lanes, triggered on exit activity, not on L0
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_fwd_seen_reg <= 1'b0;
      dn_fwd_seen_reg <= 4'h0;
    end else begin
      up_fwd_seen_reg <= up_exit_seen_i;
      dn_fwd_seen_reg <= dn_exit_seen_i;
    end
  end

  assign any_dn_exit = |dn_exit_seen_i;
  // Only own traffic or an upstream exit wakes a downstream link
  assign dn_trig = dn_tx_pending_i | {4{up_exit_seen_i}};

  apmx_fwd_lane u_up_lane (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .trig_i    (up_tx_pending_i || any_dn_exit),
    .link_l1_i (up_link_l1_i),
    .block_i   (1'b0),
    .exit_o    (up_lane_exit)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_dn
      apmx_fwd_lane u_dn_lane (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .trig_i    (dn_trig[gi]),
        .link_l1_i (dn_link_l1_i[gi]),
        .block_i   (dn_dstate_low_i[gi]),
        .exit_o    (dn_lane_exit[gi])
      );
    end
  endgenerate

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_exit_o <= 1'b0;
      dn_exit_o <= 4'h0;
    end else begin
      up_exit_o <= up_lane_exit && up_link_l1_i;
      dn_exit_o <= dn_lane_exit & dn_link_l1_i & ~dn_dstate_low_i;
    end
  end

  // =============================================================
  // Exit deadline supervision
  // A new start of exit activity on one side opens a window counted in
  // core clock cycles; it closes once the other side's exit command is
  // raised or nothing is left to wake. Running past the limit sets a
  // sticky late flag in the exit status word, cleared only by reset.
  assign up_exit_begin = up_exit_seen_i && !up_fwd_seen_reg;
  assign dn_exit_begin = dn_exit_seen_i & ~dn_fwd_seen_reg;
  assign dn_eligible   = dn_link_l1_i & ~dn_dstate_low_i;
  assign dn_waiting    = |(dn_target_reg & dn_eligible & ~dn_exit_o);

  always @* begin
    up_dl_run_next = up_dl_run_reg;
    up_dl_cnt_next = up_dl_cnt_reg;
    up_late_next   = up_late_reg;
    if (!up_link_l1_i || up_exit_o) begin
      // Exit already commanded, or the link is out of L1
      up_dl_run_next = 1'b0;
      up_dl_cnt_next = 8'h00;
    end else if (|dn_exit_begin && !up_dl_run_reg) begin
      up_dl_run_next = 1'b1;
      up_dl_cnt_next = 8'h00;
    end else if (up_dl_run_reg) begin
      if (up_dl_cnt_reg >= `APMX_FWD_LIMIT_CNT) begin
        up_late_next   = 1'b1;
        up_dl_run_next = 1'b0;
      end else begin
        up_dl_cnt_next = up_dl_cnt_reg + 8'h01;
      end
    end
  end

  always @* begin
    dn_dl_run_next = dn_dl_run_reg;
    dn_dl_cnt_next = dn_dl_cnt_reg;
    dn_target_next = dn_target_reg;
    dn_late_next   = dn_late_reg;
    if (up_exit_begin && !dn_dl_run_reg) begin
      // Only links eligible at the start are owed an exit
      dn_dl_run_next = |dn_eligible;
      dn_dl_cnt_next = 8'h00;
      dn_target_next = dn_eligible;
    end else if (dn_dl_run_reg) begin
      if (!dn_waiting) begin
        dn_dl_run_next = 1'b0;
        dn_dl_cnt_next = 8'h00;
        dn_target_next = 4'h0;
      end else if (dn_dl_cnt_reg >= `APMX_FWD_LIMIT_CNT) begin
        dn_late_next   = 1'b1;
        dn_dl_run_next = 1'b0;
        dn_target_next = 4'h0;
      end else begin
        dn_dl_cnt_next = dn_dl_cnt_reg + 8'h01;
      end
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_dl_run_reg <= 1'b0;
      up_dl_cnt_reg <= 8'h00;
      up_late_reg   <= 1'b0;
      dn_dl_run_reg <= 1'b0;
      dn_dl_cnt_reg <= 8'h00;
      dn_target_reg <= 4'h0;
      dn_late_reg   <= 1'b0;
    end else begin
      up_dl_run_reg <= up_dl_run_next;
      up_dl_cnt_reg <= up_dl_cnt_next;
      up_late_reg   <= up_late_next;
      dn_dl_run_reg <= dn_dl_run_next;
      dn_dl_cnt_reg <= dn_dl_cnt_next;
      dn_target_reg <= dn_target_next;
      dn_late_reg   <= dn_late_next;
    end
  end

endmodule // apmx_top

// ### bench/apmx_monitor.sv
/* Checker for the exit forwarding and bus answer of apmx_top.
   Bound to apmx_top; sees only its ports. */
`timescale 1ns/10ps
// ====
// Checker
module apmx_monitor (
  input wire       clk_i,
  input wire       arst_n_i,
  input wire       avs_read_i,
  input wire       avs_waitrequest_o,
  input wire       up_link_l1_i,
  input wire       up_exit_seen_i,
  input wire       up_tx_pending_i,
  input wire [3:0] dn_link_l1_i,
  input wire [3:0] dn_exit_seen_i,
  input wire [3:0] dn_tx_pending_i,
  input wire [3:0] dn_dstate_low_i,
  input wire       up_exit_o,
  input wire [3:0] dn_exit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence up_held; up_link_l1_i [*7]; endsequence
  sequence dn_free; dn_link_l1_i == 4'hF && dn_dstate_low_i == 4'h0; endsequence
  up_wake_a: assert property (up_tx_pending_i ##0 up_held |=> up_exit_o)
    else $error("no up exit on traffic");
  up_fwd_a: assert property (|dn_exit_seen_i ##0 up_held |=> up_exit_o)
    else $error("no up exit forward");
  dn_fwd_a: assert property (up_exit_seen_i ##0 dn_free [*7] |=> dn_exit_o == 4'hF)
    else $error("no dn exit forward");
  dn_wake_a: assert property (dn_tx_pending_i[1] ##0 (dn_link_l1_i[1] && !dn_dstate_low_i[1]) [*7]
    |=> dn_exit_o[1]) else $error("no dn exit on traffic");
  dstate_skip_a: assert property (!(|(dn_dstate_low_i & $past(dn_dstate_low_i) & dn_exit_o)))
    else $error("exit on low power link");
  other_dn_a: assert property ((!up_exit_seen_i && !dn_tx_pending_i[2]) [*8] |=> !$rose(dn_exit_o[2]))
    else $error("spurious dn exit");
  l0_idle_a: assert property (!dn_link_l1_i[0] [*3] |-> !dn_exit_o[0])
    else $error("exit on L0 link");
  bus_ack_a: assert property ($rose(avs_read_i) |-> ##[1:2] !avs_waitrequest_o)
    else $error("bus answer late");
endmodule // apmx_monitor

bind apmx_top apmx_monitor u_apmx_monitor (.clk_i, .arst_n_i, .avs_read_i, .avs_waitrequest_o, .up_link_l1_i,
  .up_exit_seen_i, .up_tx_pending_i, .dn_link_l1_i, .dn_exit_seen_i, .dn_tx_pending_i, .dn_dstate_low_i,
  .up_exit_o, .dn_exit_o);

// ### bench/apmx_partner.sv
/* Link partner model for one link of the switch.
   Shares clock and reset with the device. */
`timescale 1ns/10ps
// ====
// Partner
module apmx_partner #(
  parameter int LAT = 20
) (
  input  wire  clk_i,
  input  wire  arst_n_i,
  input  wire  exit_i,
  input  wire  wake_i,
  input  wire  sleep_i,
  output logic l1_o,
  output logic seen_o
);
  int cnt;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      l1_o <= 1'h1;
      seen_o <= 1'h0;
      cnt <= 0;
    end else if (sleep_i) begin
      l1_o <= 1'h1;
      seen_o <= 1'h0;
      cnt <= 0;
    end else if (l1_o && (wake_i || exit_i || seen_o)) begin
      seen_o <= cnt != LAT;
      l1_o <= cnt != LAT;
      cnt <= cnt + 1;
    end
  end
endmodule // apmx_partner

// ### bench/apmx_top_tb.sv
/* Testbench for apmx_top: bus, exit forwarding, configuration bits.
   Needs the partner model and checker compiled first. */
`timescale 1ns/10ps
// ====
// Bench
module apmx_top_tb;
  logic        clk_i = 0, arst_n_i = 0, avs_read_i = 0, avs_write_i = 0, slot_clock_i = 0;
  logic        up_tx_pending_i = 0, retrain_done_i = 0, up_wake = 0, dn_wake = 0, sleep = 0;
  logic [3:0]  avs_address_i = '0, dn_tx_pending_i = '0, dn_dstate_low_i = '0;
  logic [31:0] avs_writedata_i = '0, rd;
  logic [2:0]  dl = 3'h7;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, up_link_l1_i, up_exit_seen_i, up_exit_o, p0_l1, p0_seen, retrain_req_o;
  wire  [3:0]  dn_exit_o;
  wire  [1:0]  lowpower_entry_enable_o;
  wire  [3:0]  dn_link_l1_i = {dl, p0_l1};
  wire  [3:0]  dn_exit_seen_i = {3'h0, p0_seen};
  int          errors = 0, n_compared = 0, cyc = 0, n, n_retrain = 0;
  always #2 clk_i = ~clk_i;
  apmx_top u_apmx_top (.clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .slot_clock_i, .up_link_l1_i, .up_exit_seen_i,
    .up_tx_pending_i, .retrain_done_i, .dn_link_l1_i, .dn_exit_seen_i, .dn_tx_pending_i, .dn_dstate_low_i,
    .up_exit_o, .dn_exit_o, .lowpower_entry_enable_o, .retrain_req_o);
  apmx_partner #(.LAT(60)) u_apmx_partner_up (.clk_i, .arst_n_i, .exit_i(up_exit_o), .wake_i(up_wake),
    .sleep_i(sleep), .l1_o(up_link_l1_i), .seen_o(up_exit_seen_i));
  apmx_partner #(.LAT(40)) u_apmx_partner_dn (.clk_i, .arst_n_i, .exit_i(dn_exit_o[0]), .wake_i(dn_wake),
    .sleep_i(sleep), .l1_o(p0_l1), .seen_o(p0_seen));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'h0) @(posedge clk_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // Waits for any exit output picked by the mask, counting cycles
  task wt(input logic [4:0] m);
    n = 0;
    while (({up_exit_o, dn_exit_o} & m) === 5'h0) begin
      n++;
      @(posedge clk_i);
    end
  endtask
  // Far sides finish their exit, then every link returns to L1
  task rest;
    repeat (100) @(posedge clk_i);
    dl <= 3'h0;
    sleep <= 1'h1;
    @(posedge clk_i);
    sleep <= 1'h0;
    dn_dstate_low_i <= 4'h0;
    repeat (4) @(posedge clk_i);
    dl <= 3'h7;
    repeat (4) @(posedge clk_i);
  endtask
  task pulse_wake(input logic up);
    if (up) up_wake <= 1'h1;
    else dn_wake <= 1'h1;
    @(posedge clk_i);
    up_wake <= 1'h0;
    dn_wake <= 1'h0;
  endtask
  task t_regs;
    slot_clock_i <= 1'h1;
    bus(1, 4'h0, 32'hFFFFFFFF);
    bus(0, 4'h0, 32'h0);
    chk(rd[7:0], {3'h4, 3'h5, 2'h3});
    bus(0, 4'h4, 32'h0);
    chk(rd[2:0], 3'h0);
    bus(0, 4'h8, 32'h0);
    chk(rd[0], 1'h1);
    bus(0, 4'h2, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_ctrl;
    for (int m = 0; m < 4; m++) begin
      bus(1, 4'h4, m);
      chk(lowpower_entry_enable_o, m);
    end
    bus(1, 4'h4, 32'hC);
    chk(n_retrain, 32'h1);
    bus(0, 4'h0, 32'h0);
    chk(rd[7:0], {3'h4, 3'h5, 2'h3});
    retrain_done_i <= 1'h1;
    @(posedge clk_i);
    retrain_done_i <= 1'h0;
    bus(0, 4'h0, 32'h0);
    chk(rd[7:0], {3'h2, 3'h3, 2'h3});
    bus(0, 4'h4, 32'h0);
    chk(rd[2], 1'h1);
  endtask
  task t_up;
    pulse_wake(0);
    wt(5'h10);
    chk(n < 250, 32'h1);
    chk({p0_l1, dn_exit_o[3:1]}, 4'h8);
    repeat (100) @(posedge clk_i);
    chk({up_link_l1_i, up_exit_o}, 2'h0);
    rest;
  endtask
  task t_dn;
    dl <= 3'h6;
    dn_dstate_low_i <= 4'h4;
    pulse_wake(1);
    wt(5'h0F);
    chk(n < 250, 32'h1);
    chk({up_link_l1_i, dn_exit_o}, 5'h19);
    rest;
  endtask
  task t_own;
    dn_tx_pending_i <= 4'h2;
    @(posedge clk_i);
    dn_tx_pending_i <= 4'h0;
    wt(5'h0F);
    repeat (2) @(posedge clk_i);
    chk({up_exit_o, dn_exit_o}, 5'h02);
    bus(0, 4'hC, 32'h0);
    chk(rd, 32'h3E4);
    up_tx_pending_i <= 1'h1;
    @(posedge clk_i);
    up_tx_pending_i <= 1'h0;
    wt(5'h10);
    chk(n < 250, 32'h1);
  endtask
  task stop_test;
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'h1;
    @(posedge clk_i);
    t_regs;
    t_ctrl;
    t_up;
    t_dn;
    t_own;
    stop_test;
  end
  always @(posedge clk_i) begin
    if (retrain_req_o === 1'h1) n_retrain++;
    cyc++;
    if (cyc == 3000) begin
      chk(32'h0, 32'h1);
      stop_test;
    end
  end
endmodule // apmx_top_tb
